// file: verilog/exception_and_low_power_control.sv
// Exception arbitration, break handling and wait/stop sequencing, with APB registers.
// Assumes a core that pulses instrDone, waitExec, stopExec and serviceDone, and level requests.
//
// What this block does
// - Seventeen maskable sources get two-byte vectors, flag 17 lowest at FFDA, flag 1 FFFA.
// - Flags map to clock, converter, keypad, serial, timers, PLL, low voltage, external.
// - Reset outranks everything, unarbitrated, vector at FFFE and FFFF.
// - Break forces the vector fetch to the software interrupt vector at FFFC.
// - Middle status register shows flags 14 to 7, read-only, resets to zero.
// - High status register shows flags 17 to 15, one when pending.
// - In break, other modules' flags cannot clear unless break-clear-enable is set.
// - A flag cleared during break stays cleared after break.
// - Two-step clears stay protected in break; second step works after break.
// - Wait or stop halts core clocks and clears the interrupt mask.
// - Wait gates core clocks, peripheral clocks keep running.
// - In wait, stacking starts one cycle after the interrupt arrives.
// - Reset or break also exits wait; break exit sets the stop/wait status bit.
// - With watchdog-disable option zero, watchdog runs, also during wait.
// - Stop clears the system counter and disables the clock generator output.
// - Stop exits on interrupt, reset or break; stacking waits for full recovery, except on reset.
// - Recovery is 4096 cycles, or 32 with short-recovery select set.
// - Break during stop sets the stop/wait status bit.
// - System counter held cleared through stop, then times the recovery.
// - Stop/wait status bit clears on a written zero and on reset.
// - System counter is twelve bits and advances on the falling clock edge.
// - In run, a latched exception holds off all others except reset until serviced, or for a non-break vector until the mask input drops.
// - Break-clear-enable is read/write bit 7 of break flag control, reset zero.
//
// Our own choice: the APB slave port.
`include "exc_lp_defs.svh"

module exception_and_low_power_control (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Requests
    input  wire logic [17:1] irqReq,
    input  wire logic        irqMask,
    input  wire logic        resetReq,
    input  wire logic        breakReq,
    // Core handshake
    input  wire logic        instrDone,
    input  wire logic        serviceDone,
    input  wire logic        waitExec,
    input  wire logic        stopExec,
    output logic             excTake,
    output logic      [15:0] vectorAddr,
    output logic             excLatched,
    output logic             clearIMask,
    // Clocks and status
    output logic             cpuClkEn,
    output logic             periphClkEn,
    output logic             clockGenEn,
    output logic             breakState,
    output logic             flagClearAllow,
    output logic             watchdogEnable,
    output logic             watchdogTick
);

    exc_lp_pkg::power_state_t state;
    exc_lp_pkg::power_state_t next_state;

    logic [17:1] pendFlags;
    logic        breakClearEnable;
    logic        breakStopWait;
    logic        shortRecovery;
    logic        watchdogDisable;
    logic [11:0] sysCount;
    logic [11:0] recCnt;
    logic [15:0] winnerVector;
    logic        anyIrq;
    logic        winnerValid;
    logic        wakeReq;
    logic        recoverDone;
    logic        takeNow;
    logic        breakExit;
    logic        setupPhase;
    logic        accessWr;
    logic [31:0] readMux;
    logic        readHit;

    assign anyIrq      = |irqReq;
    assign winnerValid = resetReq | breakReq | (anyIrq & ~irqMask);
    // Mask was cleared on entry, so any request wakes
    assign wakeReq     = resetReq | breakReq | anyIrq;
    assign setupPhase  = psel & ~penable;
    assign accessWr    = psel & penable & pwrite;

    // Lowest flag number wins among maskable sources
    always_comb begin
        winnerVector = `VEC_IRQ_BASE;
        for (int i = 17; i >= 1; i--) begin
            if (irqReq[i]) begin
                winnerVector = `VEC_IRQ_BASE - 16'(2 * i);
            end
        end
        if (breakReq) begin
            winnerVector = `VEC_SOFT_IRQ;
        end
        if (resetReq) begin
            winnerVector = `VEC_RESET;
        end
    end

    // Full count lands on the wrapped zero, so recovery spans all of its cycles
    assign recoverDone = (state == exc_lp_pkg::PWR_RECOVER) &&
                         (sysCount == 12'(shortRecovery ? `RECOVER_SHORT_CYC : `RECOVER_LONG_CYC));

    always_comb begin
        next_state = state;
        takeNow    = 1'b0;
        breakExit  = 1'b0;
        case (state)
            exc_lp_pkg::PWR_RUN: begin
                if (stopExec) begin
                    next_state = exc_lp_pkg::PWR_STOP;
                end else if (waitExec) begin
                    next_state = exc_lp_pkg::PWR_WAIT;
                end else if (instrDone && winnerValid && (!excLatched || resetReq)) begin
                    takeNow = 1'b1;
                end
            end
            exc_lp_pkg::PWR_WAIT: begin
                if (wakeReq) begin
                    takeNow    = 1'b1;
                    breakExit  = breakReq & ~resetReq;
                    next_state = exc_lp_pkg::PWR_RUN;
                end
            end
            exc_lp_pkg::PWR_STOP: begin
                if (resetReq) begin
                    takeNow    = 1'b1;
                    next_state = exc_lp_pkg::PWR_RUN;
                end else if (wakeReq) begin
                    breakExit  = breakReq;
                    next_state = exc_lp_pkg::PWR_RECOVER;
                end
            end
            default: begin
                if (resetReq) begin
                    takeNow    = 1'b1;
                    next_state = exc_lp_pkg::PWR_RUN;
                end else if (recoverDone) begin
                    takeNow    = wakeReq;
                    next_state = exc_lp_pkg::PWR_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= exc_lp_pkg::PWR_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Vector latch; stacking starts the cycle after the take
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            excTake    <= 1'b0;
            excLatched <= 1'b0;
            vectorAddr <= `VEC_RESET;
        end else begin
            excTake <= takeNow;
            if (takeNow) begin
                excLatched <= 1'b1;
                vectorAddr <= winnerVector;
            end else if (serviceDone || (excLatched && !irqMask && vectorAddr != `VEC_SOFT_IRQ)) begin
                excLatched <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            breakState <= 1'b0;
        end else if (takeNow && breakReq && !resetReq) begin
            breakState <= 1'b1;
        end else if (serviceDone || (takeNow && resetReq)) begin
            breakState <= 1'b0;
        end
    end

    // Set wins over the software clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            breakStopWait <= 1'b0;
        end else if (breakExit) begin
            breakStopWait <= 1'b1;
        end else if (accessWr && paddr == `ADDR_BREAK_STATUS && !pwdata[`BSW_BIT]) begin
            breakStopWait <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clearIMask  <= 1'b0;
            cpuClkEn    <= 1'b1;
            periphClkEn <= 1'b1;
            clockGenEn  <= 1'b1;
        end else begin
            clearIMask  <= (state == exc_lp_pkg::PWR_RUN) && (waitExec || stopExec);
            cpuClkEn    <= (next_state == exc_lp_pkg::PWR_RUN);
            periphClkEn <= (next_state == exc_lp_pkg::PWR_RUN) || (next_state == exc_lp_pkg::PWR_WAIT);
            clockGenEn  <= (next_state != exc_lp_pkg::PWR_STOP);
        end
    end

    // Free-running prescaler, cleared for the whole of stop
    always_ff @(negedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sysCount <= 12'h000;
        end else if (state == exc_lp_pkg::PWR_STOP) begin
            sysCount <= 12'h000;
        end else begin
            sysCount <= sysCount + 12'h001;
        end
    end

    assign watchdogEnable = ~watchdogDisable;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            watchdogTick <= 1'b0;
        end else begin
            watchdogTick <= watchdogEnable && (sysCount == `SYS_COUNT_MAX);
        end
    end

    // Peripherals keep their flags unless this is high
    assign flagClearAllow = ~breakState | breakClearEnable;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pendFlags <= 17'h0_0000;
        end else begin
            pendFlags <= irqReq;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            breakClearEnable <= 1'b0;
            shortRecovery    <= 1'b0;
            watchdogDisable  <= 1'b0;
        end else if (accessWr) begin
            if (paddr == `ADDR_BREAK_FLAG_CTRL) begin
                breakClearEnable <= pwdata[`CLEAR_EN_BIT];
            end else if (paddr == `ADDR_FIRST_CONFIG) begin
                shortRecovery   <= pwdata[`SHORT_REC_BIT];
                watchdogDisable <= pwdata[`WDDIS_BIT];
            end
        end
    end

    always_comb begin
        readMux = 32'h0000_0000;
        readHit = 1'b1;
        if (paddr == `ADDR_PEND_MID) begin
            readMux[7:0] = pendFlags[14:7];
        end else if (paddr == `ADDR_PEND_HIGH) begin
            readMux[2:0] = pendFlags[17:15];
        end else if (paddr == `ADDR_BREAK_STATUS) begin
            readMux[`BSW_BIT] = breakStopWait;
        end else if (paddr == `ADDR_BREAK_FLAG_CTRL) begin
            readMux[`CLEAR_EN_BIT] = breakClearEnable;
        end else if (paddr == `ADDR_FIRST_CONFIG) begin
            readMux[`SHORT_REC_BIT] = shortRecovery;
            readMux[`WDDIS_BIT] = watchdogDisable;
        end else begin
            readHit = 1'b0;
        end
    end

    // Read data captured in setup so it comes from a flop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            prdata  <= pwrite ? 32'h0000_0000 : readMux;
            pslverr <= ~readHit;
        end
    end

    assign pready = psel & penable;

    // Cycles spent in recovery, for checking only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            recCnt <= 12'h000;
        end else if (state != exc_lp_pkg::PWR_RECOVER) begin
            recCnt <= 12'h000;
        end else begin
            recCnt <= recCnt + 12'h001;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_stop_entry;
        state == exc_lp_pkg::PWR_RUN && stopExec ##1 state == exc_lp_pkg::PWR_STOP;
    endsequence

    sequence s_recover_end;
        state == exc_lp_pkg::PWR_RECOVER && !resetReq ##1 state == exc_lp_pkg::PWR_RUN;
    endsequence

    AST_IRQ1_VECTOR: assert property (
        (state == exc_lp_pkg::PWR_RUN && instrDone && !excLatched && !stopExec && !waitExec
         && !resetReq && !breakReq && !irqMask && irqReq == 17'h0_0001) |=> vectorAddr == 16'hFFFA)
        else $error("Flag 1 did not select its vector");

    AST_IRQ17_VECTOR: assert property (
        (state == exc_lp_pkg::PWR_RUN && instrDone && !excLatched && !stopExec && !waitExec
         && !resetReq && !breakReq && !irqMask && irqReq == 17'h1_0000) |=> vectorAddr == 16'hFFDA)
        else $error("Flag 17 did not select its vector");

    AST_RESET_VECTOR: assert property (
        takeNow && resetReq |=> excTake && vectorAddr == 16'hFFFE)
        else $error("Reset did not win arbitration");

    AST_BREAK_VECTOR: assert property (
        takeNow && breakReq && !resetReq |=> vectorAddr == 16'hFFFC && breakState)
        else $error("Break did not force the software vector");

    AST_PEND_MID_READ: assert property (
        setupPhase && !pwrite && paddr == `ADDR_PEND_MID |=> prdata == {24'h00_0000, $past(pendFlags[14:7])})
        else $error("Middle status read wrong");

    AST_BREAK_PROTECT: assert property (
        breakState && !breakClearEnable |-> !flagClearAllow)
        else $error("Flags clearable in break without enable");

    AST_WAIT_CLOCKS: assert property (
        state == exc_lp_pkg::PWR_RUN && waitExec |=> !cpuClkEn && periphClkEn)
        else $error("Wait clock gating wrong");

    AST_WAIT_WAKE: assert property (
        state == exc_lp_pkg::PWR_WAIT && anyIrq |=> excTake && state == exc_lp_pkg::PWR_RUN)
        else $error("Wait wake not one cycle");

    AST_STOP_COUNTER: assert property (
        s_stop_entry ##1 state == exc_lp_pkg::PWR_STOP |-> sysCount == 12'h000 && !clockGenEn)
        else $error("Stop did not clear counter or clocks");

    AST_RECOVER_LEN: assert property (
        s_recover_end |-> $past(recCnt) == ($past(shortRecovery) ? 12'h01F : 12'hFFF))
        else $error("Stop recovery length wrong");

    AST_BSW_CLEAR: assert property (
        accessWr && paddr == `ADDR_BREAK_STATUS && !pwdata[`BSW_BIT] && !breakExit |=> !breakStopWait)
        else $error("Status bit not cleared by write of zero");

    AST_LATCH_HOLD: assert property (
        excLatched && !takeNow |=> $stable(vectorAddr))
        else $error("Latched vector changed");

endmodule // exception_and_low_power_control

// file: verilog/exc_lp_defs.svh
// Offsets, field positions, vectors and counts for the exception and low-power block.
// Assumes APB byte addresses of four times each register index.
`ifndef EXC_LP_DEFS_SVH
`define EXC_LP_DEFS_SVH

`define IDX_BREAK_STATUS     16'hFE00
`define IDX_BREAK_FLAG_CTRL  16'hFE03
`define IDX_PEND_MID         16'hFE05
`define IDX_PEND_HIGH        16'hFE06
`define IDX_FIRST_CONFIG     16'hFE07
`define ADDR_BREAK_STATUS    32'h0003_F800
`define ADDR_BREAK_FLAG_CTRL 32'h0003_F80C
`define ADDR_PEND_MID        32'h0003_F814
`define ADDR_PEND_HIGH       32'h0003_F818
`define ADDR_FIRST_CONFIG    32'h0003_F81C

`define BSW_BIT              1
`define CLEAR_EN_BIT         7
`define SHORT_REC_BIT        0
`define WDDIS_BIT            1

`define VEC_RESET            16'hFFFE
`define VEC_SOFT_IRQ         16'hFFFC
`define VEC_IRQ_BASE         16'hFFFC

`define RECOVER_LONG_CYC     13'h1000
`define RECOVER_SHORT_CYC    13'h0020
`define RECOVER_LONG_LAST    12'hFFF
`define RECOVER_SHORT_LAST   12'h01F
`define SYS_COUNT_MAX        12'hFFF

`endif

// file: verilog/exc_lp_pkg.sv
// Types for the exception and low-power block.
// Assumes nothing beyond a SystemVerilog compiler.
package exc_lp_pkg;
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_WAIT,
        PWR_STOP,
        PWR_RECOVER
    } power_state_t;
endpackage

// file: sim/core_model.sv
// Behavioural core: instruction boundaries, interrupt mask bit and return from service.
// Assumes the exception block's take pulse, latch, mask clear and core clock enable on the same clock.
module core_model #(
    parameter int SERVICE_CYCLES = 40
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // From the exception block
    input  wire logic excTake,
    input  wire logic excLatched,
    input  wire logic clearIMask,
    input  wire logic cpuClkEn,
    // To the exception block
    output logic      instrDone,
    output logic      serviceDone,
    output logic      irqMask
);
    timeunit 1ns;
    timeprecision 1ps;

    logic iBit;
    int   serviceCount;

    // Stacking sets the mask, so it is up from the moment of latching
    assign irqMask = iBit | excLatched;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            instrDone    <= 1'b0;
            serviceDone  <= 1'b0;
            iBit         <= 1'b0;
            serviceCount <= 0;
        end else begin
            instrDone   <= cpuClkEn;
            serviceDone <= cpuClkEn && serviceCount == 1;
            if (clearIMask || (cpuClkEn && serviceCount == 1)) begin
                iBit <= 1'b0;
            end
            if (excTake) begin
                iBit         <= 1'b1;
                serviceCount <= SERVICE_CYCLES;
            end else if (cpuClkEn && serviceCount != 0) begin
                serviceCount <= serviceCount - 1;
            end
        end
    end
endmodule // core_model

// file: sim/exception_and_low_power_control_test.sv
// Self-checking bench: APB register access, exception arbitration, break, wait and stop.
// Assumes the core model on the far side and byte addresses from the shared defines.
`include "exc_lp_defs.svh"

module exception_and_low_power_control_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [17:1] irqReq, req;
    logic        irqMask, resetReq, breakReq, instrDone, serviceDone, waitExec, stopExec;
    logic        excTake, excLatched, clearIMask, cpuClkEn, periphClkEn, clockGenEn;
    logic        breakState, flagClearAllow, watchdogEnable, watchdogTick, err;
    logic [15:0] vectorAddr;
    int          miscompares, checked, cnt, takes, ticks;

    exception_and_low_power_control uut (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irqReq(irqReq), .irqMask(irqMask), .resetReq(resetReq), .breakReq(breakReq),
        .instrDone(instrDone), .serviceDone(serviceDone), .waitExec(waitExec), .stopExec(stopExec),
        .excTake(excTake), .vectorAddr(vectorAddr), .excLatched(excLatched), .clearIMask(clearIMask),
        .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn), .clockGenEn(clockGenEn),
        .breakState(breakState), .flagClearAllow(flagClearAllow),
        .watchdogEnable(watchdogEnable), .watchdogTick(watchdogTick)
    );

    core_model #(.SERVICE_CYCLES(40)) core (
        .clk(clk), .rst_b(rst_b), .excTake(excTake), .excLatched(excLatched),
        .clearIMask(clearIMask), .cpuClkEn(cpuClkEn), .instrDone(instrDone),
        .serviceDone(serviceDone), .irqMask(irqMask)
    );

    always #5 clk = ~clk;

    // Prescaler overflow pulses seen over the whole run
    always @(posedge clk) begin
        if (watchdogTick === 1'b1) begin
            ticks++;
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Idle edge at the end keeps the next setup off the release time step
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            miscompares++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic regCheck(input logic [31:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0000_0000);
        check(what, exp, rd);
    endtask

    task automatic pulse(input logic w, input logic s);
        waitExec <= w;
        stopExec <= s;
        @(posedge clk);
        waitExec <= 1'b0;
        stopExec <= 1'b0;
    endtask

    task automatic waitTake();
        cnt = 0;
        do begin
            @(posedge clk);
            cnt++;
        end while (excTake !== 1'b1 && cnt < 5000);
        if (excTake !== 1'b1) begin
            miscompares++;
        end
    endtask

    task automatic waitFree();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (excLatched !== 1'b0 && n < 200);
        check("latch", 32'h0, 32'(excLatched));
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        give_verdict();
    end

    initial begin
        {clk, rst_b, psel, penable, pwrite, resetReq, breakReq, waitExec, stopExec} = '0;
        paddr = '0;
        pwdata = '0;
        irqReq = '0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check("reset vector", 32'h0000_FFFE, 32'(vectorAddr));
        regCheck(`ADDR_PEND_MID, 32'h0, "pending mid");
        regCheck(`ADDR_PEND_HIGH, 32'h0, "pending high");
        regCheck(`ADDR_BREAK_FLAG_CTRL, 32'h0, "clear enable");
        regCheck(`ADDR_BREAK_STATUS, 32'h0, "stop wait status");
        apb(1'b1, `ADDR_PEND_MID, 32'h0000_00FF);
        regCheck(`ADDR_PEND_MID, 32'h0, "pending mid write");
        apb(1'b0, 32'h0000_0100, 32'h0);
        check("unmapped", 32'h1, 32'(err));
        // Flags n..17 pending at once: flag n must win
        for (int n = 17; n >= 1; n--) begin
            req = 17'h1_FFFF << (n - 1);
            irqReq <= req;
            waitTake();
            check("vector", 32'(16'hFFFC - 16'(2 * n)), 32'(vectorAddr));
            regCheck(`ADDR_PEND_MID, 32'(req[14:7]), "pending mid");
            regCheck(`ADDR_PEND_HIGH, 32'(req[17:15]), "pending high");
            irqReq <= '0;
            waitFree();
        end
        irqReq <= 17'h1_0000;
        waitTake();
        irqReq <= 17'h0_0001;
        takes = 0;
        repeat (20) begin
            @(posedge clk);
            takes += int'(excTake === 1'b1);
        end
        check("takes while latched", 32'h0, 32'(takes));
        waitTake();
        check("vector after service", 32'h0000_FFFA, 32'(vectorAddr));
        irqReq <= 17'h0_0001;
        resetReq <= 1'b1;
        waitTake();
        check("reset wins", 32'h0000_FFFE, 32'(vectorAddr));
        resetReq <= 1'b0;
        irqReq <= '0;
        waitFree();
        breakReq <= 1'b1;
        waitTake();
        breakReq <= 1'b0;
        @(posedge clk);
        check("break vector", 32'h0000_FFFC, 32'(vectorAddr));
        check("break state", 32'h1, 32'(breakState));
        check("protected", 32'h0, 32'(flagClearAllow));
        apb(1'b1, `ADDR_BREAK_FLAG_CTRL, 32'h0000_0080);
        check("clear allowed", 32'h1, 32'(flagClearAllow));
        regCheck(`ADDR_BREAK_FLAG_CTRL, 32'h0000_0080, "clear enable");
        apb(1'b1, `ADDR_BREAK_FLAG_CTRL, 32'h0);
        check("protected again", 32'h0, 32'(flagClearAllow));
        waitFree();
        check("after break", 32'h1, 32'(flagClearAllow));
        pulse(1'b1, 1'b0);
        @(posedge clk);
        check("mask cleared", 32'h1, 32'(clearIMask));
        check("core clock wait", 32'h0, 32'(cpuClkEn));
        check("periph clock wait", 32'h1, 32'(periphClkEn));
        check("watchdog on", 32'h1, 32'(watchdogEnable));
        repeat (5) @(posedge clk);
        irqReq <= 17'h0_0008;
        waitTake();
        check("wait wake edges", 32'h2, 32'(cnt));
        check("wait vector", 32'h0000_FFF4, 32'(vectorAddr));
        irqReq <= '0;
        waitFree();
        for (int s = 0; s < 2; s++) begin
            pulse(s == 0, s == 1);
            repeat (3) @(posedge clk);
            breakReq <= 1'b1;
            waitTake();
            breakReq <= 1'b0;
            regCheck(`ADDR_BREAK_STATUS, 32'h2, "break exit status");
            apb(1'b1, `ADDR_BREAK_STATUS, 32'h0);
            regCheck(`ADDR_BREAK_STATUS, 32'h0, "status cleared");
            waitFree();
        end
        apb(1'b1, `ADDR_FIRST_CONFIG, 32'h0000_0001);
        pulse(1'b0, 1'b1);
        @(posedge clk);
        check("clock gen stop", 32'h0, 32'(clockGenEn));
        check("periph clock stop", 32'h0, 32'(periphClkEn));
        check("core clock stop", 32'h0, 32'(cpuClkEn));
        repeat (5) @(posedge clk);
        irqReq <= 17'h0_0100;
        waitTake();
        check("short recovery", 32'h1, 32'(cnt >= 32 && cnt <= 38));
        check("stop vector", 32'h0000_FFEA, 32'(vectorAddr));
        irqReq <= '0;
        waitFree();
        pulse(1'b0, 1'b1);
        repeat (3) @(posedge clk);
        resetReq <= 1'b1;
        waitTake();
        resetReq <= 1'b0;
        check("reset exits stop", 32'h1, 32'(cnt <= 3 && vectorAddr === 16'hFFFE));
        waitFree();
        apb(1'b1, `ADDR_FIRST_CONFIG, 32'h0000_0000);
        pulse(1'b0, 1'b1);
        repeat (3) @(posedge clk);
        irqReq <= 17'h1_0000;
        waitTake();
        check("long recovery", 32'h1, 32'(cnt >= 4096 && cnt <= 4102));
        irqReq <= '0;
        waitFree();
        check("watchdog ticks", 32'h1, 32'(ticks > 0));
        apb(1'b1, `ADDR_FIRST_CONFIG, 32'h0000_0002);
        check("watchdog off", 32'h0, 32'(watchdogEnable));
        give_verdict();
    end
endmodule // exception_and_low_power_control_test
